// file: common/ilr_pkg.sv
// Package: constants and types for the interrupt log ring writer
package ilr_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 16;
  localparam int          IRQ_W           = 16;
  localparam logic [15:0] RING_BASE       = 16'h0040;
  localparam logic [15:0] RING_LAST_INFO  = 16'h005E;
  localparam logic [15:0] RING_LAST_SRC   = 16'h005F;
  localparam logic [15:0] HW_SOURCE_WORD  = 16'h0000;
  localparam logic [15:0] HW_TYPE_MASK    = 16'h00FF;
  localparam logic [15:0] MSG_TYPE_MASK   = 16'hFF00;
  localparam logic [15:0] BIT_MSG_ERROR   = 16'h0400;
  localparam logic [15:0] BIT_WHEN_ACC    = 16'h4000;
  localparam logic [7:0]  COUNT_MAX       = 8'hFF;
  localparam logic [7:0]  COUNT_RESET     = 8'h00;
  localparam logic [7:0]  OVERRUN_LIMIT   = 8'h10;

  typedef enum logic [1:0] {
    ILR_IDLE   = 2'b00,
    ILR_INFO   = 2'b01,
    ILR_SOURCE = 2'b11
  } ilr_state_type;
endpackage : ilr_pkg

// file: rtl/ilr_writer.sv
// Interrupt log ring writer: stores two-word records of enabled interrupts in shared RAM
// Notes on behaviour
// RULE1: Entry is info word even, source odd.
// RULE2: After fifteenth event pointer sits at 005E.
// RULE3: After sixteenth entry pointer reloads 0040.
// RULE4: Message error logs 0400 with receive descriptor.
// RULE5: Accessed event needs enable and descriptor bit.
// RULE6: Accessed event logs 4000 with transmit descriptor.
// RULE7: Hardware interrupts log zero source word.
// RULE8: Event count saturates 255, above 16 overrun.
// RULE9: Resets set pointer low byte to 0040.
// RULE10: Disabled interrupt types produce no entry.
// RULE11: Info word first, pointer plus one each.
`timescale 1ns/1ps
`default_nettype none
module ilr_writer
  import ilr_pkg::*;
(
  input  wire  logic                      sys_clk,          // 40 MHz device clock
  input  wire  logic                      arst_n,           // Asynchronous reset, active low
  input  wire  logic                      master_reset_pin, // Master reset request, synchronous
  input  wire  logic                      soft_reset_bit,   // Software reset request
  input  wire  logic [ilr_pkg::IRQ_W-1:0] irq_enable,       // Interrupt enable register contents
  input  wire  logic                      hw_event,         // Hardware interrupt strobe
  input  wire  logic [ilr_pkg::IRQ_W-1:0] hw_type,          // Hardware interrupt type bits
  input  wire  logic                      msg_event,        // Message interrupt strobe
  input  wire  logic [ilr_pkg::IRQ_W-1:0] msg_type,         // Message interrupt type bits
  input  wire  logic                      desc_irq_access,  // Descriptor control word access bit
  input  wire  logic [ilr_pkg::ADDR_W-1:0] desc_addr,       // Descriptor control word address
  input  wire  logic                      log_read,         // Log address register was read
  output logic                            ram_we,           // RAM write strobe
  output logic       [ilr_pkg::ADDR_W-1:0] ram_addr,        // RAM write address
  output logic       [ilr_pkg::DATA_W-1:0] ram_wdata,       // RAM write data
  output logic                            event_ready,      // High when idle and able to take a new event
  output logic       [ilr_pkg::DATA_W-1:0] log_addr_reg,    // Count in 15:8, pointer in 7:0
  output logic                            overrun           // More than 16 events unread
);
  import ilr_pkg::*;

  ilr_state_type           state_r;
  ilr_state_type           state_nxt;
  logic [7:0]              ptr_r;
  logic [7:0]              count_r;
  logic [IRQ_W-1:0]        info_r;
  logic [ADDR_W-1:0]       src_r;
  logic                    ram_we_r;
  logic [ADDR_W-1:0]       ram_addr_r;
  logic [DATA_W-1:0]       ram_wdata_r;
  logic                    ready_r;
  logic                    overrun_r;
  logic [IRQ_W-1:0]        msg_bits;
  logic [IRQ_W-1:0]        hw_bits;
  logic [IRQ_W-1:0]        ev_bits;
  logic                    take;
  logic                    sreset;

  function automatic logic [7:0] ptr_step(input logic [7:0] p);
    if (p == RING_LAST_SRC[7:0]) begin
      ptr_step = RING_BASE[7:0]; // RULE3
    end else begin
      ptr_step = p + 8'h01; // RULE11
    end
  endfunction : ptr_step

  assign sreset = master_reset_pin | soft_reset_bit;

  // Accessed bit only passes with the descriptor bit also set
  always_comb begin
    msg_bits = msg_type & irq_enable & MSG_TYPE_MASK; // RULE10
    if (!desc_irq_access) begin
      msg_bits = msg_bits & ~BIT_WHEN_ACC; // RULE5
    end
    hw_bits = hw_type & irq_enable & HW_TYPE_MASK; // RULE10
  end

  // Message events take priority; a hardware event in the same cycle is dropped
  always_comb begin
    if (msg_event && (msg_bits != '0)) begin
      ev_bits = msg_bits;
    end else if (hw_event && (hw_bits != '0)) begin
      ev_bits = hw_bits;
    end else begin
      ev_bits = '0;
    end
  end
  assign take = (state_r == ILR_IDLE) && (ev_bits != '0) && !sreset;

  always_comb begin
    case (state_r)
      ILR_IDLE:   state_nxt = take ? ILR_INFO : ILR_IDLE;
      ILR_INFO:   state_nxt = ILR_SOURCE;
      ILR_SOURCE: state_nxt = ILR_IDLE;
      default:    state_nxt = ILR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ILR_IDLE;
    end else if (sreset) begin
      state_r <= ILR_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Capture the record when an event is taken
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      info_r <= '0;
      src_r  <= '0;
    end else if (take) begin
      info_r <= ev_bits; // RULE4 RULE6
      if (msg_event && (msg_bits != '0)) begin
        src_r <= desc_addr; // RULE4 RULE6
      end else begin
        src_r <= HW_SOURCE_WORD; // RULE7
      end
    end
  end

  // Pointer steps once per stored word and wraps after the last
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_r <= RING_BASE[7:0];
    end else if (sreset) begin
      ptr_r <= RING_BASE[7:0]; // RULE9
    end else if (state_r == ILR_INFO || state_r == ILR_SOURCE) begin
      ptr_r <= ptr_step(ptr_r); // RULE2 RULE3 RULE11
    end
  end

  // RAM write port
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ram_we_r    <= 1'b0;
      ram_addr_r  <= '0;
      ram_wdata_r <= '0;
    end else begin
      ram_we_r <= 1'b0;
      if (!sreset && state_r == ILR_INFO) begin
        ram_we_r    <= 1'b1;
        ram_addr_r  <= {8'h00, ptr_r};
        ram_wdata_r <= info_r; // RULE1 RULE11
      end else if (!sreset && state_r == ILR_SOURCE) begin
        ram_we_r    <= 1'b1;
        ram_addr_r  <= {8'h00, ptr_r};
        ram_wdata_r <= src_r; // RULE1 RULE7
      end
    end
  end

  // Event count since last read; a new event in the read cycle counts as one
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= COUNT_RESET;
    end else if (sreset) begin
      count_r <= COUNT_RESET;
    end else if (log_read) begin
      count_r <= take ? 8'h01 : COUNT_RESET; // RULE8
    end else if (take && count_r != COUNT_MAX) begin
      count_r <= count_r + 8'h01; // RULE8
    end
  end

  // Overrun flag moves with the count, so the output stays a flip-flop
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      overrun_r <= 1'b0;
    end else if (sreset || log_read) begin
      overrun_r <= 1'b0;
    end else if (take && count_r == OVERRUN_LIMIT) begin
      overrun_r <= 1'b1; // RULE8
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_r <= 1'b1;
    end else begin
      ready_r <= sreset || ((state_nxt == ILR_IDLE) && !take);
    end
  end

  assign ram_we       = ram_we_r;
  assign ram_addr     = ram_addr_r;
  assign ram_wdata    = ram_wdata_r;
  assign event_ready  = ready_r;
  assign log_addr_reg = {count_r, ptr_r};
  assign overrun      = overrun_r;

  AST_INFO_EVEN: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_r == ILR_INFO && !sreset |=> ram_we && !ram_addr[0] && ram_wdata == $past(info_r)) // RULE1
    else $error("Info word not at even address");
  AST_SRC_FOLLOWS: assert property (@(posedge sys_clk) disable iff (!arst_n || sreset)
    ram_we && !ram_addr[0] |=> ram_we && ram_addr == $past(ram_addr) + 16'h0001) // RULE11
    else $error("Source word not at next address");
  AST_LAST_SLOT: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ram_we && ram_addr == RING_LAST_SRC |-> ptr_r == RING_BASE[7:0]) // RULE3
    else $error("Pointer not wrapped after last slot");
  AST_PTR_EVEN_IDLE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_r == ILR_IDLE |-> !ptr_r[0] && ptr_r >= RING_BASE[7:0] && ptr_r <= RING_LAST_INFO[7:0]) // RULE2
    else $error("Idle pointer out of ring");
  AST_RESET_PTR: assert property (@(posedge sys_clk) disable iff (!arst_n)
    sreset |=> ptr_r == RING_BASE[7:0] && count_r == COUNT_RESET) // RULE9
    else $error("Reset did not reload pointer");
  AST_HW_ZERO: assert property (@(posedge sys_clk) disable iff (!arst_n || sreset)
    take && !(msg_event && msg_bits != '0) |-> ##3 ram_we && ram_addr[0] && ram_wdata == HW_SOURCE_WORD) // RULE7
    else $error("Hardware source word not zero");
  AST_MSG_SRC: assert property (@(posedge sys_clk) disable iff (!arst_n || sreset)
    take && msg_event && msg_bits != '0 |-> ##3 ram_we && ram_wdata == $past(desc_addr, 3)) // RULE4
    else $error("Message source word wrong");
  AST_ACCESS_GATED: assert property (@(posedge sys_clk) disable iff (!arst_n)
    take && !desc_irq_access |-> !ev_bits[14]) // RULE5
    else $error("Accessed event without descriptor bit");
  AST_ACCESS_WORD: assert property (@(posedge sys_clk) disable iff (!arst_n || sreset)
    take && msg_bits == BIT_WHEN_ACC && msg_event |-> ##2 ram_we && ram_wdata == BIT_WHEN_ACC) // RULE6
    else $error("Accessed info word wrong");
  AST_ENABLE_ONLY: assert property (@(posedge sys_clk) disable iff (!arst_n)
    take |-> (ev_bits & ~irq_enable) == '0) // RULE10
    else $error("Disabled type logged");
  AST_COUNT_SAT: assert property (@(posedge sys_clk) disable iff (!arst_n)
    count_r == COUNT_MAX && !log_read && !sreset |=> count_r == COUNT_MAX) // RULE8
    else $error("Count did not saturate");
  AST_OVERRUN_FLAG: assert property (@(posedge sys_clk) disable iff (!arst_n)
    overrun == (count_r > OVERRUN_LIMIT)) // RULE8
    else $error("Overrun flag disagrees with count");
endmodule : ilr_writer
`default_nettype wire

// file: verification/ilr_ram_model.sv
// Host-side model of the shared RAM that holds the interrupt log
`timescale 1ns/1ps
`default_nettype none
module ilr_ram_model
  import ilr_pkg::*;
(
  input  wire logic                       sys_clk,   // Device clock
  input  wire logic                       ram_we,    // Write strobe
  input  wire logic [ilr_pkg::ADDR_W-1:0] ram_addr,  // Write address
  input  wire logic [ilr_pkg::DATA_W-1:0] ram_wdata, // Write data
  output logic      [15:0]                wr_cnt     // Words written at any address
);
  logic [15:0] mem [0:31];
  logic [15:0] wr_cnt_r = 16'h0000;
  assign wr_cnt = wr_cnt_r;
  // Only ring words are kept, so a stray address shows up as a missing entry
  always @(posedge sys_clk) begin
    if (ram_we) begin
      wr_cnt_r <= wr_cnt_r + 16'h0001;
      if (ram_addr[15:5] == 11'h002) begin
        mem[ram_addr[4:0]] <= ram_wdata;
      end
    end
  end
endmodule : ilr_ram_model
`default_nettype wire

// file: verification/ilr_writer_tb.sv
// Self-checking testbench for the interrupt log ring writer
`timescale 1ns/1ps
`default_nettype none
module ilr_writer_tb;
  import ilr_pkg::*;
  logic        sys_clk = 0, arst_n = 0, master_reset_pin = 0, soft_reset_bit = 0, log_read = 0;
  logic        hw_event = 0, msg_event = 0, desc_irq_access = 0, ram_we, event_ready, overrun;
  logic [15:0] irq_enable = 16'hFFFF, hw_type = '0, msg_type = '0, desc_addr = '0;
  logic [15:0] ram_addr, ram_wdata, log_addr_reg, wr_cnt, wc = '0;
  logic [7:0]  cnt = '0, ptr = 8'h40;
  int          mismatches = 0, check_count = 0;
  always #12.5 sys_clk = ~sys_clk;
  ilr_writer dut (.sys_clk, .arst_n, .master_reset_pin, .soft_reset_bit, .irq_enable, .hw_event, .hw_type,
    .msg_event, .msg_type, .desc_irq_access, .desc_addr, .log_read, .ram_we, .ram_addr, .ram_wdata,
    .event_ready, .log_addr_reg, .overrun);
  ilr_ram_model ram (.sys_clk, .ram_we, .ram_addr, .ram_wdata, .wr_cnt);
  task automatic chk(input logic [15:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  // One strobe, then enough idle cycles for both words to land
  task automatic ev(input logic m, input logic [15:0] t, input logic a, input logic [15:0] d);
    {msg_event, hw_event, desc_irq_access} = {m, !m, a};
    {msg_type, hw_type, desc_addr} = {t, t, d};
    step(1);
    {msg_event, hw_event} = '0;
    step(4);
  endtask : ev
  task automatic logged(input logic [15:0] info, src);
    wc = wc + 16'h0002;
    chk(wr_cnt, wc, "write count");
    chk(ram.mem[ptr[4:0]], info, "info word");
    chk(ram.mem[ptr[4:0] + 5'h01], src, "source word");
    ptr = (ptr == 8'h5E) ? 8'h40 : ptr + 8'h02;
    cnt = (cnt == 8'hFF) ? cnt : cnt + 8'h01;
    chk(log_addr_reg, {cnt, ptr}, "log address");
  endtask : logged
  task automatic t_types();
    chk(log_addr_reg, 16'h0040, "reset pointer");
    ev(1'b1, BIT_MSG_ERROR, 1'b0, 16'h0278);
    logged(16'h0400, 16'h0278);
    ev(1'b1, BIT_WHEN_ACC, 1'b1, 16'h02F8);
    logged(16'h4000, 16'h02F8);
    ev(1'b0, 16'h0010, 1'b0, 16'h1234);
    logged(16'h0010, HW_SOURCE_WORD);
    $display("test types done");
  endtask : t_types
  task automatic t_refused();
    ev(1'b1, BIT_WHEN_ACC, 1'b0, 16'h02F8);
    irq_enable = 16'hFBEF;
    ev(1'b1, BIT_MSG_ERROR, 1'b0, 16'h0278);
    ev(1'b0, 16'h0010, 1'b0, 16'h0000);
    irq_enable = 16'hFFFF;
    chk(wr_cnt, wc, "refused writes");
    chk(log_addr_reg, {cnt, ptr}, "refused pointer");
    $display("test refused done");
  endtask : t_refused
  // A strobe held while busy is dropped; a message beats a hardware event
  task automatic t_busy();
    {hw_event, hw_type} = {1'b1, 16'h0001};
    step(1);
    chk({15'h0000, event_ready}, 16'h0000, "busy ready");
    hw_type = 16'h0002;
    step(1);
    hw_event = 1'b0;
    step(3);
    chk({15'h0000, event_ready}, 16'h0001, "idle ready");
    logged(16'h0001, HW_SOURCE_WORD);
    {msg_event, msg_type, desc_addr, hw_event, hw_type} = {1'b1, BIT_MSG_ERROR, 16'h0278, 1'b1, 16'h0010};
    step(1);
    {msg_event, hw_event} = '0;
    step(4);
    logged(BIT_MSG_ERROR, 16'h0278);
    $display("test busy done");
  endtask : t_busy
  task automatic t_ring();
    log_read = 1'b1;
    step(1);
    log_read = 1'b0;
    cnt = '0;
    for (int i = 0; i < 260; i++) begin
      ev(1'b0, 16'h0001 << (i % 8), 1'b0, 16'h0000);
      logged(16'h0001 << (i % 8), HW_SOURCE_WORD);
      if (i inside {15, 16}) chk({15'h0000, overrun}, {15'h0000, i == 16}, "overrun");
    end
    $display("test ring done");
  endtask : t_ring
  task automatic t_resets();
    for (int k = 0; k < 2; k++) begin
      ev(1'b0, 16'h0002, 1'b0, 16'h0000);
      logged(16'h0002, HW_SOURCE_WORD);
      {master_reset_pin, soft_reset_bit} = k ? 2'b01 : 2'b10;
      {hw_event, hw_type} = {1'b1, 16'h0004};
      step(1);
      {master_reset_pin, soft_reset_bit, hw_event} = '0;
      step(3);
      {cnt, ptr} = 16'h0040;
      chk(log_addr_reg, 16'h0040, "sync reset pointer");
      chk(wr_cnt, wc, "reset drops event");
    end
    $display("test resets done");
  endtask : t_resets
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  initial begin
    #200us;
    mismatches++;
    summarize();
  end
  initial begin
    step(6);
    arst_n = 1'b1;
    t_types();
    t_refused();
    t_busy();
    t_ring();
    t_resets();
    summarize();
  end
endmodule : ilr_writer_tb
`default_nettype wire
